// [verilog/rsl_pkg.sv]
// constants and types shared by the rotate, shift and logic datapath
package rsl_pkg;

    // opcode nibbles (instruction bits 7:4)
    localparam logic [3:0] OP_ROTATE_LEFT           = 4'h9;
    localparam logic [3:0] OP_ROTATE_LEFT_VIA_FLAG  = 4'h1;
    localparam logic [3:0] OP_ROTATE_RIGHT          = 4'hE;
    localparam logic [3:0] OP_ROTATE_RIGHT_VIA_FLAG = 4'hC;
    localparam logic [3:0] OP_BORROW_DIFFERENCE     = 4'h3;
    localparam logic [3:0] OP_SUBTRACT              = 4'h2;
    localparam logic [3:0] OP_ARITH_SHIFT_RIGHT     = 4'hD;
    localparam logic [3:0] OP_NIBBLE_SWAP           = 4'hF;
    localparam logic [3:0] OP_INVERTED_MASK_TEST    = 4'h6;
    localparam logic [3:0] OP_MASK_TEST             = 4'h7;
    localparam logic [3:0] OP_XOR                   = 4'hB;

    // whole instruction bytes
    localparam logic [7:0] INSTR_FORCE_CARRY_ONE    = 8'hDF;
    localparam logic [7:0] INSTR_LOAD_GROUP_POINTER = 8'h31;

    // operand mode nibbles (instruction bits 3:0)
    localparam logic [3:0] MODE_DIRECT    = 4'h0;
    localparam logic [3:0] MODE_INDIRECT  = 4'h1;
    localparam logic [3:0] MODE_WORK_WORK = 4'h2;
    localparam logic [3:0] MODE_WORK_IND  = 4'h3;
    localparam logic [3:0] MODE_REG_REG   = 4'h4;
    localparam logic [3:0] MODE_REG_IND   = 4'h5;
    localparam logic [3:0] MODE_REG_IMM   = 4'h6;
    localparam logic [3:0] MODE_IND_IMM   = 4'h7;

    // flag vector layout
    localparam int         FLAGS_W    = 6;
    localparam int         FLAG_C     = 0;
    localparam int         FLAG_Z     = 1;
    localparam int         FLAG_S     = 2;
    localparam int         FLAG_V     = 3;
    localparam int         FLAG_D     = 4;
    localparam int         FLAG_H     = 5;
    localparam logic [5:0] FLAGS_RESET = 6'h00;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_INSTR     = 8'h00;
    localparam logic [7:0] IDX_BYTE_A    = 8'h01;
    localparam logic [7:0] IDX_BYTE_B    = 8'h02;
    localparam logic [7:0] IDX_FLAGS     = 8'h03;
    localparam logic [7:0] IDX_STATUS    = 8'h04;
    localparam logic [7:0] IDX_GROUP_PTR = 8'hFD;

    localparam logic [7:0] GROUP_PTR_RESET = 8'h00;
    localparam logic [3:0] PTR_LOW_ZERO    = 4'h0;
    localparam logic [3:0] PTR_BAD_LO      = 4'h8;
    localparam logic [3:0] PTR_BAD_HI      = 4'hE;

    // status word fields
    localparam int STAT_WRITTEN_BIT = 8;
    localparam int STAT_ERROR_BIT   = 9;
    localparam int STAT_MODE_LSB    = 10;
    localparam int STAT_PTR_BAD_BIT = 14;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } rsl_state_e;

endpackage

// [verilog/rsl_alu.sv]
// combinational byte datapath: rotates, shift, subtracts, logic, flags
`timescale 1ns/1ns
module rsl_alu (
    input  wire logic [3:0]                  opNib,
    input  wire logic                        forceCarry,
    input  wire logic [rsl_pkg::FLAGS_W-1:0] flagsIn,
    input  wire logic [7:0]                  dstIn,
    input  wire logic [7:0]                  srcIn,
    output logic      [7:0]                  result,
    output logic      [rsl_pkg::FLAGS_W-1:0] flagsOut,
    output logic                             writeDst
);
    import rsl_pkg::*;

    logic       carryIn;
    logic [8:0] diff;
    logic [4:0] lowDiff;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        carryIn = flagsIn[FLAG_C] & (opNib == OP_BORROW_DIFFERENCE);
        diff    = {1'b0, dstIn} - {1'b0, srcIn} - {8'h00, carryIn};
        lowDiff = {1'b0, dstIn[3:0]} - {1'b0, srcIn[3:0]}
                  - {4'h0, carryIn};
        result   = dstIn;
        flagsOut = flagsIn;
        writeDst = 1'b0;
        if (forceCarry) begin
            flagsOut[FLAG_C] = 1'b1;
        end else begin
            case (opNib)
                OP_ROTATE_LEFT: begin
                    result           = {dstIn[6:0], dstIn[7]};
                    flagsOut[FLAG_C] = dstIn[7];
                    flagsOut[FLAG_V] = result[7] ^ dstIn[7];
                    writeDst         = 1'b1;
                end
                OP_ROTATE_LEFT_VIA_FLAG: begin
                    result           = {dstIn[6:0], flagsIn[FLAG_C]};
                    flagsOut[FLAG_C] = dstIn[7];
                    flagsOut[FLAG_V] = result[7] ^ dstIn[7];
                    writeDst         = 1'b1;
                end
                OP_ROTATE_RIGHT: begin
                    result           = {dstIn[0], dstIn[7:1]};
                    flagsOut[FLAG_C] = dstIn[0];
                    flagsOut[FLAG_V] = result[7] ^ dstIn[7];
                    writeDst         = 1'b1;
                end
                OP_ROTATE_RIGHT_VIA_FLAG: begin
                    result           = {flagsIn[FLAG_C], dstIn[7:1]};
                    flagsOut[FLAG_C] = dstIn[0];
                    flagsOut[FLAG_V] = result[7] ^ dstIn[7];
                    writeDst         = 1'b1;
                end
                OP_ARITH_SHIFT_RIGHT: begin
                    result           = {dstIn[7], dstIn[7:1]};
                    flagsOut[FLAG_C] = dstIn[0];
                    flagsOut[FLAG_V] = 1'b0;
                    writeDst         = 1'b1;
                end
                OP_BORROW_DIFFERENCE, OP_SUBTRACT: begin
                    result           = diff[7:0];
                    flagsOut[FLAG_C] = diff[8];
                    flagsOut[FLAG_H] = ~lowDiff[4];
                    flagsOut[FLAG_D] = 1'b1;
                    flagsOut[FLAG_V] = (dstIn[7] ^ srcIn[7])
                                       & (diff[7] ^ dstIn[7]);
                    writeDst         = 1'b1;
                end
                OP_NIBBLE_SWAP: begin
                    result   = {dstIn[3:0], dstIn[7:4]};
                    writeDst = 1'b1;
                end
                OP_INVERTED_MASK_TEST: begin
                    result           = ~dstIn & srcIn;
                    flagsOut[FLAG_V] = 1'b0;
                end
                OP_MASK_TEST: begin
                    result           = dstIn & srcIn;
                    flagsOut[FLAG_V] = 1'b0;
                end
                OP_XOR: begin
                    result           = dstIn ^ srcIn;
                    flagsOut[FLAG_V] = 1'b0;
                    writeDst         = 1'b1;
                end
                default: begin
                    result = dstIn;
                end
            endcase
            // zero and sign follow the result for every operation here
            flagsOut[FLAG_Z] = (result == 8'h00);
            flagsOut[FLAG_S] = result[7];
        end
    end

endmodule

// [verilog/rsl_top.sv]
// APB wrapped datapath for rotate, shift, subtract and logic instructions
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module rsl_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic      [7:0]                  aluResult,
    output logic      [rsl_pkg::FLAGS_W-1:0] aluFlags,
    output logic                             dstWriteStrobe,
    output logic      [7:0]                  workingGroupPointer
);
    import rsl_pkg::*;

    if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_check
        $error("rsl_top: ADDR_W must lie in 10..32");
    end

    typedef struct packed {
        rsl_state_e        state;
        logic [7:0]        instr;
        logic [7:0]        byteA;
        logic [7:0]        byteB;
        logic [FLAGS_W-1:0] flags;
        logic [7:0]        result;
        logic [7:0]        groupPtr;
        logic              writeBack;
        logic              written;
        logic              error;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
    } rsl_regs_s;

    rsl_regs_s          stR;
    rsl_regs_s          stN;
    logic [4:0]         modeInfo;
    logic [7:0]         dstByte;
    logic [7:0]         srcByte;
    logic [7:0]         aluRes;
    logic [FLAGS_W-1:0] aluFl;
    logic               aluWr;
    logic               isScf;
    logic               isSrp;
    logic               anyHit;
    logic               ptrBad;
    logic [31:0]        rdWord;

    ////////////////////////////////////////////////////////////////////////
    // address match for one register index
    function automatic logic isReg(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        idx);
        return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    // {legal, srcFirst, srcImm, srcInd, dstInd}
    function automatic logic [4:0] decodeMode(input logic [7:0] ins);
        logic [3:0] op;
        logic [3:0] md;
        op = ins[7:4];
        md = ins[3:0];
        decodeMode = 5'h00;
        if (ins == INSTR_FORCE_CARRY_ONE
            || ins == INSTR_LOAD_GROUP_POINTER) begin
            decodeMode = {1'b1, 4'h0};
        end else begin
            case (op)
                OP_ROTATE_LEFT, OP_ROTATE_LEFT_VIA_FLAG, OP_ROTATE_RIGHT,
                OP_ROTATE_RIGHT_VIA_FLAG, OP_ARITH_SHIFT_RIGHT,
                OP_NIBBLE_SWAP: begin
                    if (md == MODE_DIRECT || md == MODE_INDIRECT) begin
                        decodeMode = {1'b1, 3'b000,
                                      md == MODE_INDIRECT};
                    end
                end
                OP_BORROW_DIFFERENCE, OP_SUBTRACT, OP_INVERTED_MASK_TEST,
                OP_MASK_TEST, OP_XOR: begin
                    if (md >= MODE_WORK_WORK && md <= MODE_IND_IMM) begin
                        decodeMode = {1'b1,
                            md == MODE_REG_REG || md == MODE_REG_IND,
                            md == MODE_REG_IMM || md == MODE_IND_IMM,
                            md == MODE_WORK_IND || md == MODE_REG_IND,
                            md == MODE_IND_IMM};
                    end
                end
                default: begin
                    decodeMode = 5'h00;
                end
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // operand selection
    assign isScf    = (stR.instr == INSTR_FORCE_CARRY_ONE);
    assign isSrp    = (stR.instr == INSTR_LOAD_GROUP_POINTER);
    assign modeInfo = decodeMode(stR.instr);
    assign dstByte  = modeInfo[3] ? stR.byteB : stR.byteA;
    assign srcByte  = modeInfo[3] ? stR.byteA : stR.byteB;
    assign ptrBad   = (stR.groupPtr[7:4] >= PTR_BAD_LO)
                      && (stR.groupPtr[7:4] <= PTR_BAD_HI);

    rsl_alu u_alu (
        .opNib      (stR.instr[7:4]),
        .forceCarry (isScf),
        .flagsIn    (stR.flags),
        .dstIn      (dstByte),
        .srcIn      (srcByte),
        .result     (aluRes),
        .flagsOut   (aluFl),
        .writeDst   (aluWr)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read mux
    always_comb begin
        rdWord = 32'h0000_0000;
        anyHit = 1'b1;
        if (isReg(paddr, IDX_INSTR)) begin
            rdWord[7:0] = stR.instr;
        end else if (isReg(paddr, IDX_BYTE_A)) begin
            rdWord[7:0] = stR.byteA;
        end else if (isReg(paddr, IDX_BYTE_B)) begin
            rdWord[7:0] = stR.byteB;
        end else if (isReg(paddr, IDX_FLAGS)) begin
            rdWord[FLAGS_W-1:0] = stR.flags;
        end else if (isReg(paddr, IDX_STATUS)) begin
            rdWord[7:0]                            = stR.result;
            rdWord[STAT_WRITTEN_BIT]               = stR.written;
            rdWord[STAT_ERROR_BIT]                 = stR.error;
            rdWord[STAT_MODE_LSB+3:STAT_MODE_LSB]  = modeInfo[3:0];
            rdWord[STAT_PTR_BAD_BIT]               = ptrBad;
        end else if (isReg(paddr, IDX_GROUP_PTR)) begin
            rdWord[7:0] = stR.groupPtr;
        end else begin
            anyHit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        stN           = stR;
        stN.writeBack = 1'b0;
        stN.pready    = 1'b0;
        case (stR.state)
            ST_IDLE: begin
                if (psel && penable && !stR.pready) begin
                    stN.pready  = 1'b1;
                    stN.pslverr = !anyHit;
                    stN.prdata  = rdWord;
                end
                if (psel && penable && stR.pready && pwrite) begin
                    if (isReg(paddr, IDX_INSTR)) begin
                        stN.instr = pwdata[7:0];
                        stN.state = ST_EXEC;
                    end
                    if (isReg(paddr, IDX_BYTE_A)) begin
                        stN.byteA = pwdata[7:0];
                    end
                    if (isReg(paddr, IDX_BYTE_B)) begin
                        stN.byteB = pwdata[7:0];
                    end
                    if (isReg(paddr, IDX_FLAGS)) begin
                        stN.flags = pwdata[FLAGS_W-1:0];
                    end
                    if (isReg(paddr, IDX_GROUP_PTR)) begin
                        stN.groupPtr = {pwdata[7:4], PTR_LOW_ZERO};
                    end
                end
            end
            ST_EXEC: begin
                stN.state = ST_IDLE;
                stN.error = !modeInfo[4];
                if (modeInfo[4] && isSrp) begin
                    stN.groupPtr = {stR.byteA[7:4], PTR_LOW_ZERO};
                    stN.written  = 1'b0;
                end else if (modeInfo[4]) begin
                    stN.result    = aluRes;
                    stN.flags     = aluFl;
                    stN.writeBack = aluWr;
                    stN.written   = aluWr;
                end
            end
            default: begin
                stN.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stR <= '{state: ST_IDLE, flags: FLAGS_RESET,
                     groupPtr: GROUP_PTR_RESET, default: '0};
        end else begin
            stR <= stN;
        end
    end

    assign prdata              = stR.prdata;
    assign pready              = stR.pready;
    assign pslverr             = stR.pslverr;
    assign aluResult           = stR.result;
    assign aluFlags            = stR.flags;
    assign dstWriteStrobe      = stR.writeBack;
    assign workingGroupPointer = stR.groupPtr;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic       execOk;
    logic       oldCarry;
    logic [3:0] opNib;
    assign execOk   = (stR.state == ST_EXEC) && modeInfo[4] && !isScf
                      && !isSrp;
    assign oldCarry = stR.flags[FLAG_C];
    assign opNib    = stR.instr[7:4];

    AST_ROTATE_LEFT: assert property (
        execOk && opNib == OP_ROTATE_LEFT |=>
        aluResult == {dstByte[6:0], dstByte[7]}
        && aluFlags[FLAG_C] == aluResult[0])
        else $error("left rotate result or carry wrong");
    AST_ROTATE_LEFT_VIA: assert property (
        execOk && opNib == OP_ROTATE_LEFT_VIA_FLAG |=>
        aluResult == {dstByte[6:0], $past(oldCarry)}
        && aluFlags[FLAG_C] == dstByte[7])
        else $error("left rotate through carry wrong");
    AST_ROTATE_RIGHT: assert property (
        execOk && opNib == OP_ROTATE_RIGHT |=>
        aluResult == {dstByte[0], dstByte[7:1]}
        && aluFlags[FLAG_C] == aluResult[7])
        else $error("right rotate result or carry wrong");
    AST_ROTATE_RIGHT_VIA: assert property (
        execOk && opNib == OP_ROTATE_RIGHT_VIA_FLAG |=>
        aluResult == {$past(oldCarry), dstByte[7:1]}
        && aluFlags[FLAG_C] == dstByte[0])
        else $error("right rotate through carry wrong");
    AST_ROTATE_FLAGS: assert property (
        execOk && (opNib == OP_ROTATE_LEFT || opNib == OP_ROTATE_RIGHT) |=>
        aluFlags[FLAG_Z] == (aluResult == 8'h00)
        && aluFlags[FLAG_S] == aluResult[7]
        && aluFlags[FLAG_V] == (aluResult[7] ^ dstByte[7])
        && $stable(aluFlags[FLAG_H]) && $stable(aluFlags[FLAG_D]))
        else $error("rotate flags wrong");
    AST_BORROW_DIFF: assert property (
        execOk && opNib == OP_BORROW_DIFFERENCE |=>
        aluResult == 8'(dstByte - srcByte - {7'h00, $past(oldCarry)})
        && aluFlags[FLAG_D] && dstWriteStrobe)
        else $error("borrow subtract result wrong");
    AST_SUBTRACT: assert property (
        execOk && opNib == OP_SUBTRACT |=>
        aluResult == 8'(dstByte - srcByte)
        && aluFlags[FLAG_C] == (dstByte < srcByte))
        else $error("subtract result or borrow wrong");
    AST_FORCE_CARRY: assert property (
        stR.state == ST_EXEC && isScf |=>
        aluFlags[FLAG_C] && $stable(aluFlags[FLAGS_W-1:1])
        && !dstWriteStrobe)
        else $error("force carry changed more than carry");
    AST_ARITH_SHIFT: assert property (
        execOk && opNib == OP_ARITH_SHIFT_RIGHT |=>
        aluResult == {dstByte[7], dstByte[7:1]}
        && aluFlags[FLAG_C] == dstByte[0] && !aluFlags[FLAG_V])
        else $error("arithmetic shift wrong");
    AST_GROUP_POINTER: assert property (
        stR.state == ST_EXEC && isSrp |=>
        workingGroupPointer == {stR.byteA[7:4], PTR_LOW_ZERO}
        && $stable(aluFlags))
        else $error("group pointer load wrong");
    AST_MASK_TEST: assert property (
        execOk && opNib == OP_MASK_TEST |=>
        !dstWriteStrobe && !aluFlags[FLAG_V]
        && aluResult == (dstByte & srcByte) && $stable(aluFlags[FLAG_C]))
        else $error("mask test wrong");
    AST_XOR: assert property (
        execOk && opNib == OP_XOR |=>
        dstWriteStrobe && aluResult == (dstByte ^ srcByte)
        && !aluFlags[FLAG_V])
        else $error("xor wrong");
    AST_APB_ANSWER: assert property (
        psel && penable && !pready && stR.state == ST_IDLE |=> pready)
        else $error("apb answer late");

    COV_ROTATE: cover property (execOk && opNib == OP_ROTATE_LEFT_VIA_FLAG);
    COV_SUBTRACT: cover property (execOk && opNib == OP_BORROW_DIFFERENCE);
    COV_POINTER: cover property (stR.state == ST_EXEC && isSrp);
    COV_UNMAPPED: cover property (pready && pslverr);

endmodule

// [testbench/rsl_apb_master.sv]
// apb master standing in for the core's decoder and sequencer
`timescale 1ns/1ns
module rsl_apb_master (
    input  wire logic        sys_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             hung
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        hung = 1'b0;
    end

    // one transfer: setup, access held until pready is seen high or 50 cycles pass
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) hung <= 1'b1;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// [testbench/rsl_top_test.sv]
// self-checking bench for the rotate, shift and logic datapath
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module rsl_top_test;
    import rsl_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel, penable, pwrite, pslverr, pready, hung;
    logic        dstWriteStrobe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  aluResult, workingGroupPointer;
    logic [5:0]  aluFlags;
    logic        e;
    int          miscompares = 0;
    int          compares = 0;

    always #4 sys_clk = ~sys_clk;

    rsl_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .aluResult(aluResult), .aluFlags(aluFlags),
        .dstWriteStrobe(dstWriteStrobe),
        .workingGroupPointer(workingGroupPointer));
    rsl_apb_master m_u (.sys_clk(sys_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung(hung));

    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge hung) begin
        miscompares++;
        end_sim;
    end

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        m_u.xfer(1'b1, {2'b00, idx, 2'b00}, {24'h000000, d}, q, e);
    endtask

    task automatic rd(input logic [11:0] a);
        m_u.xfer(1'b0, a, 32'h00000000, q, e);
    endtask

    // row: instr, byteA, byteB, flags in, result, flags out, strobe
    task automatic run_op(input logic [55:0] c);
        wr(IDX_BYTE_A, c[47:40]);
        wr(IDX_BYTE_B, c[39:32]);
        wr(IDX_FLAGS, c[31:24]);
        wr(IDX_INSTR, c[55:48]);
        repeat (1) @(posedge sys_clk);
        #1;
        if (c[55:48] != INSTR_FORCE_CARRY_ONE &&
            c[55:48] != INSTR_LOAD_GROUP_POINTER)
            `CHK(aluResult, c[23:16])
        `CHK(aluFlags, c[13:8])
        `CHK(dstWriteStrobe, c[0])
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd({2'b00, IDX_FLAGS, 2'b00});
        `CHK(q, 32'h00000000)
        rd({2'b00, IDX_GROUP_PTR, 2'b00});
        `CHK(q, 32'h00000000)
    endtask

    task t_rotates;
        run_op(56'h90880000110901);
        run_op(56'h108F00301E3901);
        run_op(56'hE1310000980D01);
        run_op(56'hC0DD00006E0901);
        run_op(56'hC0010000000301);
        run_op(56'hD0B8003BDC3401);
    endtask

    task t_subtracts;
        run_op(56'h32160501103001);
        run_op(56'h26291100183001);
        run_op(56'h22000101FF1501);
        run_op(56'h24112900183001);
        run_op(56'h228001007F1801);
    endtask

    task t_logic;
        run_op(56'hDF00003E003F00);
        run_op(56'hF00B0000B00401);
        run_op(56'h62F60609000300);
        run_op(56'h72F60609060100);
        run_op(56'hB6C37B39B83501);
    endtask

    task t_pointer;
        run_op(56'h3175002A002A00);
        `CHK(workingGroupPointer, 8'h70)
        wr(IDX_GROUP_PTR, 8'hF0);
        rd({2'b00, IDX_GROUP_PTR, 2'b00});
        `CHK(q, 32'h000000F0)
    endtask

    task t_refused;
        wr(IDX_INSTR, 8'h20);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(aluResult, 8'hB8)
        rd({2'b00, IDX_STATUS, 2'b00});
        `CHK(q[STAT_ERROR_BIT], 1'b1)
        rd(12'h014);
        `CHK({e, q}, {1'b1, 32'h00000000})
        rd(12'h001);
        `CHK(e, 1'b1)
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset;
        t_rotates;
        t_subtracts;
        t_logic;
        t_refused;
        t_pointer;
        end_sim;
    end
endmodule
